// ### design/smc_speed_ctrl.sv
// Speed-mode command selection, ramp and run/brake sequencing.
// Assumes all inputs synchronous to clock; rst models power-up.
`timescale 1ns/100ps
`default_nettype none
`include "smc_defs.svh"

// Summary of operation
// - Analog enabled: set 1 uses external voltage
// - Analog command scaled by gain, max 5500
// - Analog speed below clamp forced to zero
// - Clamp ignored in servo-lock mode
// - Manual offset subtracted before scaling
// - Apply request captures zero-volt reading as offset
// - Analog sets share knob accel/decel time
// - Analog enabled: sets 2-7 digital
// - Analog disabled: all eight sets digital
// - System settings take effect at power-up
// - Free mode: de-energise at standstill, energise on run
// - Servo lock: energise follows servo-on input
// - Brake released exactly while energised
// - Run inputs map to direction by setting
// - Negative command reverses direction
// - Ready at zero ramp with no run input, when brake-release (and servo-on) allow
// - One run input: ramp up, removal: ramp down
// - Both run inputs: decelerate to stop
// - Zero-speed after run ends within band
// - Free: brake output off after 10 ms still
// - Select bits form binary set number
// - Lock, servo-on low: clear deviation, ignore runs
module smc_speed_ctrl #(
  parameter int unsigned STILL_CYCLES = `SMC_STILL_TIME_MS * `SMC_CLK_KHZ
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              analog_enable_cfg,
  input  wire logic              stop_lock_cfg,
  input  wire logic              dir_plus_cw_cfg,
  input  wire logic              data_select_bit0,
  input  wire logic              data_select_bit1,
  input  wire logic              data_select_bit2,
  input  wire logic              run_fwd,
  input  wire logic              run_rev,
  input  wire logic              servo_on,
  input  wire logic              brake_release_in,
  input  wire smc_pkg::smc_mv_t  analog_in_mv,
  input  wire smc_pkg::smc_mv_t  offset_cfg_mv,
  input  wire logic              auto_offset_en,
  input  wire logic              apply_offset,
  input  wire logic [12:0]       gain_cfg,
  input  wire smc_pkg::smc_mag_t clamp_cfg,
  input  wire smc_pkg::smc_mag_t speed_trim_knob,
  input  wire logic [13:0]       accel_trim_knob,
  input  wire logic              table_wr,
  input  wire logic [2:0]        table_index,
  input  wire smc_pkg::smc_speed_t table_speed,
  input  wire smc_pkg::smc_speed_t detected_speed,
  input  wire smc_pkg::smc_mag_t zero_band_cfg,
  output logic                   energise_out,
  output logic                   brake_control_output,
  output logic                   ready_out,
  output logic                   zero_speed_output,
  output logic                   dir_cw_out,
  output smc_pkg::smc_mag_t      speed_mag_out,
  output logic                   pos_clear_out
);

  // Magnitude of a signed speed
  function automatic smc_pkg::smc_mag_t smc_abs(input smc_pkg::smc_speed_t s);
    smc_abs = s[15] ? smc_pkg::smc_mag_t'(-s) : smc_pkg::smc_mag_t'(s);
  endfunction

  // Millivolt difference times r/min per volt, saturated
  function automatic smc_pkg::smc_speed_t smc_scale(
    input logic signed [16:0] d,
    input logic        [12:0] g
  );
    logic signed [30:0] p;
    p = d * $signed({1'b0, g});
    p = p / 31'sd`SMC_MV_PER_V;
    if (p > 31'sd`SMC_SPEED_MAX)
      smc_scale = 16'sd`SMC_SPEED_MAX;
    else if (p < -31'sd`SMC_SPEED_MAX)
      smc_scale = -16'sd`SMC_SPEED_MAX;
    else
      smc_scale = smc_pkg::smc_speed_t'(p);
  endfunction

  logic               ana_en_reg;
  logic               lock_reg;
  logic               dir_cfg_reg;
  smc_pkg::smc_speed_t speed_tab_reg [`SMC_SET_COUNT];
  smc_pkg::smc_mv_t   auto_offs_reg;
  smc_pkg::smc_mag_t  ramp_mag_reg;
  logic [19:0]        ramp_cnt_reg;
  logic [31:0]        still_cnt_reg;
  smc_pkg::smc_state_t state_reg;
  logic               still_done_reg;

  logic [2:0]          sel;
  logic signed [16:0]  ana_diff;
  logic [12:0]         gain_lim;
  smc_pkg::smc_speed_t ana_raw;
  smc_pkg::smc_speed_t ana_cmd;
  smc_pkg::smc_speed_t cmd;
  logic [13:0]         accel_ms;
  logic [19:0]         step_cyc;
  logic                permitted;
  logic                run_req;
  logic                run_active;
  smc_pkg::smc_mag_t   target_mag;
  logic                det_still;
  logic                energise_next;

  // Settings sampled once at power-up; later changes wait for next reset
  always_ff @(posedge clock) begin
    if (rst) begin
      ana_en_reg  <= analog_enable_cfg;
      lock_reg    <= stop_lock_cfg;
      dir_cfg_reg <= dir_plus_cw_cfg;
    end
  end

  // Digitally stored speed per data set, zero after reset
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < `SMC_SET_COUNT; i++) begin
        speed_tab_reg[i] <= '0;
      end
    end else if (table_wr) begin
      speed_tab_reg[table_index] <= table_speed;
    end
  end

  // Host holds 0 V and pulses apply; the reading becomes the zero point
  always_ff @(posedge clock) begin
    if (rst) begin
      auto_offs_reg <= '0;
    end else if (auto_offset_en && apply_offset) begin
      auto_offs_reg <= analog_in_mv;
    end
  end

  // Analog path, evaluated every cycle so voltage changes act mid-run
  always_comb begin
    sel = {data_select_bit2, data_select_bit1, data_select_bit0};
    gain_lim = (gain_cfg > 13'(`SMC_GAIN_MAX)) ? 13'(`SMC_GAIN_MAX)
                                               : gain_cfg;
    if (auto_offset_en)
      ana_diff = 17'(analog_in_mv) - 17'(auto_offs_reg);
    else
      ana_diff = 17'(analog_in_mv) - 17'(offset_cfg_mv);
    ana_raw = smc_scale(ana_diff, gain_lim);
    if (!lock_reg && smc_abs(ana_raw) < clamp_cfg)
      ana_cmd = '0;
    else
      ana_cmd = ana_raw;
  end

  // Command and ramp time for the selected data set
  always_comb begin
    cmd = speed_tab_reg[sel];
    accel_ms = 14'(`SMC_ACCEL_DEF_MS);
    if (ana_en_reg && sel == `SMC_SET_KNOB) begin
      cmd = smc_pkg::smc_speed_t'(speed_trim_knob);
      accel_ms = accel_trim_knob;
    end else if (ana_en_reg && sel == `SMC_SET_ANALOG) begin
      cmd = ana_cmd;
      accel_ms = accel_trim_knob;
    end
    if (accel_ms < 14'(`SMC_ACCEL_MIN_MS))
      accel_ms = 14'(`SMC_ACCEL_MIN_MS);
    else if (accel_ms > 14'(`SMC_ACCEL_MAX_MS))
      accel_ms = 14'(`SMC_ACCEL_MAX_MS);
    // Cycles per 1 r/min step; 10000 ms gives 250000, fits 20 bits
    step_cyc = 20'((32'(accel_ms) * 32'(`SMC_CLK_KHZ))
                   / 32'(`SMC_ACCEL_REF_RPM));
  end

  // Run qualification; both run inputs together count as stop
  always_comb begin
    permitted  = brake_release_in && (!lock_reg || servo_on);
    run_req    = run_fwd ^ run_rev;
    run_active = run_req && permitted;
    target_mag = run_active ? smc_abs(cmd) : '0;
    det_still  = smc_abs(detected_speed) <= 16'(`SMC_STILL_RPM);
  end

  // Ramp one r/min per step; brake-release low stops at once
  always_ff @(posedge clock) begin
    if (rst || !brake_release_in) begin
      ramp_mag_reg <= '0;
      ramp_cnt_reg <= '0;
    end else if (ramp_mag_reg == target_mag) begin
      ramp_cnt_reg <= '0;
    end else if (ramp_cnt_reg >= step_cyc - 20'h00001) begin
      ramp_cnt_reg <= '0;
      if (ramp_mag_reg < target_mag)
        ramp_mag_reg <= ramp_mag_reg + 16'h0001;
      else
        ramp_mag_reg <= ramp_mag_reg - 16'h0001;
    end else begin
      ramp_cnt_reg <= ramp_cnt_reg + 20'h00001;
    end
  end

  // Run sequence state, tracks start, run and deceleration
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= smc_pkg::SMC_IDLE;
    end else begin
      unique case (state_reg)
        smc_pkg::SMC_IDLE:
          if (run_active) state_reg <= smc_pkg::SMC_RUN;
        smc_pkg::SMC_RUN:
          if (!run_active) state_reg <= smc_pkg::SMC_DECEL;
        smc_pkg::SMC_DECEL:
          if (run_active) state_reg <= smc_pkg::SMC_RUN;
          else if (ramp_mag_reg == '0) state_reg <= smc_pkg::SMC_IDLE;
      endcase
    end
  end

  // Direction held through deceleration, refreshed while running
  always_ff @(posedge clock) begin
    if (rst) begin
      dir_cw_out <= 1'b0;
    end else if (run_active) begin
      dir_cw_out <= (run_fwd ? dir_cfg_reg : !dir_cfg_reg) ^ cmd[15];
    end
  end

  // Standstill timer, saturating so it never wraps
  always_ff @(posedge clock) begin
    if (rst || !det_still) begin
      still_cnt_reg  <= '0;
      still_done_reg <= 1'b0;
    end else if (still_cnt_reg < STILL_CYCLES) begin
      still_cnt_reg  <= still_cnt_reg + 32'h00000001;
      still_done_reg <= (still_cnt_reg + 32'h00000001) >= STILL_CYCLES;
    end
  end

  // Excitation: free mode waits for true standstill before letting go
  always_comb begin
    if (lock_reg)
      energise_next = servo_on;
    else if (run_active)
      energise_next = 1'b1;
    else if (ramp_mag_reg == '0 && still_done_reg)
      energise_next = 1'b0;
    else
      energise_next = energise_out;
  end

  // Output flops; brake output shares the excitation decision
  always_ff @(posedge clock) begin
    if (rst) begin
      energise_out         <= 1'b0;
      brake_control_output <= 1'b0;
      ready_out            <= 1'b0;
      zero_speed_output    <= 1'b0;
      pos_clear_out        <= 1'b0;
      speed_mag_out        <= '0;
    end else begin
      energise_out         <= energise_next;
      brake_control_output <= energise_next;
      ready_out            <= permitted && !run_fwd && !run_rev
                              && ramp_mag_reg == '0;
      zero_speed_output    <= !run_active && ramp_mag_reg == '0
                              && smc_abs(detected_speed) <= zero_band_cfg;
      pos_clear_out        <= lock_reg && !servo_on;
      speed_mag_out        <= ramp_mag_reg;
    end
  end

  default clocking smc_cb @(posedge clock); endclocking
  default disable iff (rst);

  a_lock_excite: assert property (
    lock_reg |=> energise_out == $past(servo_on))
    else $error("servo lock excitation does not follow servo-on");
  a_brake_excite: assert property (
    brake_control_output == energise_out)
    else $error("brake output differs from excitation");
  a_still_release: assert property (
    !lock_reg && $fell(brake_control_output) |-> $past(still_done_reg))
    else $error("brake output dropped before standstill time");
  a_free_run_excite: assert property (
    !lock_reg && run_active |=> energise_out && brake_control_output)
    else $error("free mode run did not excite the motor");
  a_both_runs_stop: assert property (
    run_fwd && run_rev |=> ramp_mag_reg <= $past(ramp_mag_reg))
    else $error("speed rose with both run inputs active");
  a_ramp_step: assert property (
    brake_release_in |=> ramp_mag_reg <= $past(ramp_mag_reg) + 16'h0001)
    else $error("ramp jumped by more than one step");
  a_clamp_zero: assert property (
    !lock_reg && smc_abs(ana_raw) < clamp_cfg |-> ana_cmd == '0)
    else $error("analog speed below clamp not forced to zero");
  a_zero_speed: assert property (
    $rose(zero_speed_output) |-> $past(!run_active && ramp_mag_reg == '0))
    else $error("zero-speed raised while operating");
  a_servo_off: assert property (
    lock_reg && !servo_on |=> pos_clear_out && !energise_out
                              && !$past(run_active))
    else $error("servo-off did not clear deviation or block run");
  a_analog_sel: assert property (
    ana_en_reg && sel == `SMC_SET_ANALOG |-> cmd == ana_cmd)
    else $error("analog data set not using analog command");
  a_dir_map: assert property (
    run_active && run_fwd && !cmd[15] |=> dir_cw_out == dir_cfg_reg)
    else $error("forward run direction mapping wrong");

  c_run_start: cover property (
    state_reg == smc_pkg::SMC_IDLE ##1 state_reg == smc_pkg::SMC_RUN);
  c_decel_done: cover property (
    state_reg == smc_pkg::SMC_DECEL ##1 state_reg == smc_pkg::SMC_IDLE);
  c_brake_set: cover property (!lock_reg && $fell(brake_control_output));

endmodule
`default_nettype wire

// ### design/smc_defs.svh
// Constants for the speed-mode command and run control block.
// Assumes a 25 MHz clock; included by bare name from design files.
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

// Clock rate
`define SMC_CLK_KHZ        25000
// Analog scaling
`define SMC_MV_PER_V       1000
`define SMC_GAIN_MAX       5500
`define SMC_GAIN_DEF       550
`define SMC_SPEED_MAX      5500
// Accel/decel time in ms per reference speed step
`define SMC_ACCEL_REF_RPM  1000
`define SMC_ACCEL_MIN_MS   5
`define SMC_ACCEL_MAX_MS   10000
`define SMC_ACCEL_DEF_MS   100
// Standstill detection for brake control
`define SMC_STILL_RPM      30
`define SMC_STILL_TIME_MS  10
// Data set numbers with analog meaning
`define SMC_SET_KNOB       3'h0
`define SMC_SET_ANALOG     3'h1
`define SMC_SET_COUNT      8

`endif

// ### design/smc_pkg.sv
// Types shared by the speed-mode command and run control block.
// Assumes smc_defs.svh carries all numeric constants.
`default_nettype none
package smc_pkg;
  typedef logic signed [15:0] smc_speed_t;  // Signed r/min
  typedef logic        [15:0] smc_mag_t;    // Unsigned r/min
  typedef logic signed [15:0] smc_mv_t;     // Signed millivolts
  typedef enum logic [1:0] {
    SMC_IDLE,
    SMC_RUN,
    SMC_DECEL
  } smc_state_t;
endpackage
`default_nettype wire

// ### dv/smc_host_model.sv
// Host controller model driving the run, servo-on and brake-release pins.
// Assumes the bench sets its wishes; pins change at falling edges only.
`timescale 1ns/100ps
`default_nettype none
module smc_host_model (
  input  wire logic clock,
  input  wire logic want_fwd,
  input  wire logic want_rev,
  input  wire logic want_on,
  input  wire logic ready_out,
  output var logic  run_fwd,
  output var logic  run_rev,
  output var logic  servo_on,
  output var logic  brake_release_in
);
  logic running;

  assign running = run_fwd | run_rev;

  // Enables first; a run starts only once ready is seen, as a real host does
  // One process owns every pin, so no pin has two drivers
  initial begin
    run_fwd          = 1'b0;
    run_rev          = 1'b0;
    servo_on         = 1'b0;
    brake_release_in = 1'b0;
    forever begin
      @(negedge clock);
      brake_release_in <= want_on;
      servo_on         <= want_on;
      run_fwd <= want_fwd & (running | ready_out);
      run_rev <= want_rev & (running | ready_out);
    end
  end
endmodule
`default_nettype wire

// ### dv/speed_mode_command_and_run_control_tb_top.sv
// Self-checking bench for the speed-mode command and run control block.
// Assumes smc_host_model drives the run, servo-on and brake-release pins; bench drives the rest.
`timescale 1ns/100ps
`default_nettype none
module speed_mode_command_and_run_control_tb_top;
  typedef struct {logic [2:0] kind; logic [15:0] val;} smc_note_t;
  logic clock = 1'b0, rst = 1'b1, an_cfg = 1'b0, lk_cfg = 1'b0;
  logic dr_cfg = 1'b1, want_fwd = 1'b0, want_rev = 1'b0, want_on = 1'b0;
  logic [2:0] sel = 3'h0;
  logic run_fwd, run_rev, servo_on, brake_in, tbl_wr = 1'b0;
  logic [2:0] tbl_idx = 3'h0;
  logic [12:0] gain = 13'h0001;
  logic [13:0] accel = 14'h0005;
  logic auto_en = 1'b0, apply = 1'b0;
  smc_pkg::smc_speed_t tbl_spd = 16'h0000, det = 16'h0000;
  smc_pkg::smc_mv_t ain = 16'h0000, ofs = 16'h0000;
  logic ener, brake, ready, zero, dir, pclr;
  smc_pkg::smc_mag_t spd;
  logic [31:0] seed = 32'hDD84DE85;
  int failures = 0, samples_checked = 0;
  smc_note_t notes[$];
  event probe;

  always #20 clock = ~clock;

  smc_host_model i_smc_host_model (.clock(clock), .want_fwd(want_fwd),
    .want_rev(want_rev), .want_on(want_on), .ready_out(ready),
    .run_fwd(run_fwd), .run_rev(run_rev), .servo_on(servo_on),
    .brake_release_in(brake_in));

  // Short still time keeps the brake wait brief
  smc_speed_ctrl #(.STILL_CYCLES(20)) i_smc_speed_ctrl (.clock(clock),
    .rst(rst), .analog_enable_cfg(an_cfg), .stop_lock_cfg(lk_cfg),
    .dir_plus_cw_cfg(dr_cfg), .data_select_bit0(sel[0]),
    .data_select_bit1(sel[1]), .data_select_bit2(sel[2]),
    .run_fwd(run_fwd), .run_rev(run_rev), .servo_on(servo_on),
    .brake_release_in(brake_in), .analog_in_mv(ain), .offset_cfg_mv(ofs),
    .auto_offset_en(auto_en), .apply_offset(apply), .gain_cfg(gain),
    .clamp_cfg(16'h000A), .speed_trim_knob(16'h0001),
    .accel_trim_knob(accel), .table_wr(tbl_wr), .table_index(tbl_idx),
    .table_speed(tbl_spd), .detected_speed(det),
    .zero_band_cfg(16'h0005), .energise_out(ener),
    .brake_control_output(brake), .ready_out(ready),
    .zero_speed_output(zero), .dir_cw_out(dir), .speed_mag_out(spd),
    .pos_clear_out(pclr));

  function automatic logic [15:0] pick(input logic [2:0] k);
    case (k)
      3'h0: pick = {15'h0000, ener};
      3'h1: pick = {15'h0000, brake};
      3'h2: pick = {15'h0000, ready};
      3'h3: pick = {15'h0000, zero};
      3'h4: pick = {15'h0000, dir};
      3'h5: pick = spd;
      default: pick = {15'h0000, pclr};
    endcase
  endfunction

  // Next state of the stimulus LFSR
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check_val(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic note(input logic [2:0] k, input logic [15:0] v);
    notes.push_back('{k, v});
    -> probe;
  endtask

  // Bounded wait, then the expectation is queued whatever happened
  task automatic wait_for(input logic [2:0] k, input logic [15:0] v,
                          input int lim);
    int n;
    n = 0;
    while (pick(k) !== v && n < lim) begin
      @(negedge clock);
      n++;
    end
    note(k, v);
  endtask

  task automatic power_up(input logic an, input logic lk, input logic dr);
    rst = 1'b1;
    an_cfg = an;
    lk_cfg = lk;
    dr_cfg = dr;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
  endtask

  task automatic write_set(input logic [2:0] i, input logic [15:0] s);
    tbl_wr = 1'b1;
    tbl_idx = i;
    tbl_spd = s;
    @(negedge clock);
    tbl_wr = 1'b0;
    // Let an edge pass so back-to-back writes never retoggle the strobe
    @(negedge clock);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Oldest note is compared as soon as its result is due
  always @(probe) begin
    smc_note_t n;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      check_val(pick(n.kind), n.val);
    end
  end

  // Longest ramps need about 5000 cycles; the limit leaves ample margin
  initial begin
    repeat (60000) @(posedge clock);
    failures++;
    tally_and_finish();
  end

  initial begin
    power_up(1'b0, 1'b0, 1'b1);
    note(3'h0, 16'h0000);
    write_set(3'h2, 16'h0002);
    write_set(3'h5, 16'hFFFF);
    seed = lfsr_next(seed);
    write_set(3'h7, {4'h0, seed[11:0]});
    sel = 3'h2;
    want_on = 1'b1;
    wait_for(3'h2, 16'h0001, 20);
    det = 16'h0064 + {8'h00, seed[7:0]};
    want_fwd = 1'b1;
    wait_for(3'h0, 16'h0001, 5);
    note(3'h1, 16'h0001);
    note(3'h4, 16'h0001);
    wait_for(3'h5, 16'h0002, 6000);
    want_rev = 1'b1;
    wait_for(3'h5, 16'h0000, 6000);
    det = 16'h0000;
    wait_for(3'h3, 16'h0001, 5);
    want_fwd = 1'b0;
    want_rev = 1'b0;
    wait_for(3'h0, 16'h0000, 40);
    note(3'h1, 16'h0000);
    sel = 3'h5;
    wait_for(3'h2, 16'h0001, 20);
    want_rev = 1'b1;
    wait_for(3'h0, 16'h0001, 5);
    note(3'h4, 16'h0001);
    wait_for(3'h5, 16'h0001, 3000);
    want_rev = 1'b0;
    want_on = 1'b0;
    power_up(1'b1, 1'b1, 1'b0);
    lk_cfg = 1'b0;
    wait_for(3'h6, 16'h0001, 5);
    note(3'h0, 16'h0000);
    want_on = 1'b1;
    wait_for(3'h0, 16'h0001, 5);
    note(3'h1, 16'h0001);
    note(3'h6, 16'h0000);
    sel = 3'h1;
    ain = 16'h0BB8;
    ofs = 16'h03E8;
    wait_for(3'h2, 16'h0001, 20);
    want_fwd = 1'b1;
    wait_for(3'h5, 16'h0002, 600);
    note(3'h4, 16'h0000);
    ain = 16'h1388;
    wait_for(3'h5, 16'h0004, 600);
    want_fwd = 1'b0;
    wait_for(3'h5, 16'h0000, 1200);
    // Captured zero point: random reading held during the apply pulse
    seed = lfsr_next(seed);
    ain = {8'h00, seed[7:0]};
    auto_en = 1'b1;
    apply = 1'b1;
    @(negedge clock);
    apply = 1'b0;
    ain = ain + 16'h0BB8;
    want_fwd = 1'b1;
    wait_for(3'h5, 16'h0003, 600);
    want_fwd = 1'b0;
    wait_for(3'h5, 16'h0000, 800);
    // Knob set shares the knob ramp time
    sel = 3'h0;
    wait_for(3'h2, 16'h0001, 20);
    want_fwd = 1'b1;
    wait_for(3'h5, 16'h0001, 300);
    want_fwd = 1'b0;
    wait_for(3'h5, 16'h0000, 300);
    repeat (40) @(negedge clock);
    note(3'h0, 16'h0001);
    @(negedge clock);
    tally_and_finish();
  end
endmodule
`default_nettype wire
